// File: rtl/sbq_top.sv
// baud timer, port tick selection and port zero frame queue with APB
`timescale 1ns/100ps
`include "sbq_defs.svh"
module sbq_top
  import sbq_pkg::*;
(
  input  wire logic        CLK_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic        PERIPH_RST_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  input  wire logic [3:0]  PSTRB_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        RX_BYTE_VALID_IN,
  input  wire logic [7:0]  RX_BYTE_IN,
  input  wire logic        TX_DONE_IN,
  output logic             TX_LOAD_OUT,
  output logic      [7:0]  TX_BYTE_OUT,
  output logic             RX_CPU_VALID_OUT,
  output logic      [7:0]  RX_CPU_BYTE_OUT,
  output logic             PORT0_TICK_OUT,
  output logic             PORT1_TICK_OUT,
  output logic             RX_IRQ_FLAG_OUT,
  output logic             TX_IRQ_FLAG_OUT
);
  // registers seen by software
  logic [7:0]  baud_ctrl_reg;        // run and divide select
  logic [7:0]  reload_lo_reg;        // reload low byte
  logic [7:0]  reload_hi_reg;        // reload high byte
  logic [7:0]  rx_ctrl_reg;          // receive queue control
  logic [7:0]  tx_ctrl_reg;          // transmit queue control
  logic [7:0]  tx_ptr_reg;           // transmit buffer pointer
  logic [7:0]  tx_cnt_reg;           // transmit byte count
  logic [7:0]  rx_ptr_reg;           // receive buffer pointer
  logic [7:0]  rx_cnt_reg;           // receive byte count
  logic [7:0]  rx_match_reg;         // match value
  sbq_mode_t   mode_reg;             // port mode select
  // baud path
  logic [15:0] timer_reg;            // up counter
  logic [3:0]  ovf_cnt_reg;          // overflows per tick
  logic [1:0]  div4_reg;             // port one divider
  logic [2:0]  div6_reg;             // fixed sixth divider
  logic [3:0]  div16_reg;            // fixed sixteenth divider
  logic        run_dly_reg;          // run bit one clock ago
  // queue ram and arbiter
  logic [7:0]  ram_mem [0:255];      // queue buffer memory
  sbq_ram_t    ram_own_reg;          // who holds the ram port
  logic        rx_pend_reg;          // rx byte awaiting write
  logic [7:0]  rx_data_reg;          // latched rx byte
  logic        tx_busy_reg;          // byte handed to port
  logic        tx_fetch_reg;         // tx fetch pending
  logic [2:0]  stall_reg;            // cpu wait counter
  logic [31:0] prdata_next;          // read mux
  logic        acc;                  // access phase
  logic        wr;                   // write access
  logic        ram_hit;              // address in ram window
  logic        ram_busy;             // queue owns ram this cycle
  logic        tmr_ovf;              // timer overflow
  logic        tick_raw;             // baud tick
  logic        rx_take;              // byte offered to active queue, pause not checked
  logic        rx_last;              // count about to hit zero
  logic        tx_last;              // tx count about to hit zero

  // byte lane merge of a write into an 8-bit register
  function automatic logic [7:0] lane(input logic [7:0] old,
                                      input logic [11:0] a);
    logic [1:0] b;
    b = a[1:0];
    lane = PSTRB_IN[b] ? PWDATA_IN[8*b +: 8] : old;
  endfunction

  assign acc     = PSEL_IN && PENABLE_IN;
  assign wr      = acc && PWRITE_IN && PREADY_OUT;
  assign ram_hit = PADDR_IN[11:10] == `SBQ_RAM_SEL;
  assign ram_busy = ram_own_reg != SBQ_RAM_IDLE;
  assign tmr_ovf = baud_ctrl_reg[`SBQ_B_RUN] && run_dly_reg &&
                   timer_reg == `SBQ_TOP16;
  assign tick_raw = tmr_ovf && ovf_cnt_reg == `SBQ_OVF_PER_TICK;
  assign rx_take = RX_BYTE_VALID_IN && rx_ctrl_reg[`SBQ_B_EN] &&
                   rx_ctrl_reg[`SBQ_B_ACTIVE] && !rx_pend_reg;
  assign rx_last = rx_cnt_reg == `SBQ_ONE8;
  assign tx_last = tx_cnt_reg == `SBQ_ONE8;

  // cpu reset side: baud control, reload, mode
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      baud_ctrl_reg <= `SBQ_ZERO8;
      reload_lo_reg <= `SBQ_ZERO8;
      reload_hi_reg <= `SBQ_ZERO8;
      mode_reg      <= SBQ_MODE_SHIFT;
    end else if (wr) begin
      // reserved bits 7..2 never stored
      if (PADDR_IN == `SBQ_A_BAUD_CTRL)
        baud_ctrl_reg <= lane(baud_ctrl_reg, PADDR_IN) &
                         `SBQ_BAUD_WMASK;
      if (PADDR_IN == `SBQ_A_RELOAD_LO)
        reload_lo_reg <= lane(reload_lo_reg, PADDR_IN);
      if (PADDR_IN == `SBQ_A_RELOAD_HI)
        reload_hi_reg <= lane(reload_hi_reg, PADDR_IN);
      if (PADDR_IN == `SBQ_A_SER_MODE && PSTRB_IN[0])
        mode_reg <= sbq_mode_t'(PWDATA_IN[1:0]);
    end
  end

  // baud timer: load on start, count, reload on overflow
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      timer_reg   <= 16'h0000;
      run_dly_reg <= 1'b0;
      ovf_cnt_reg <= 4'h0;
    end else begin
      run_dly_reg <= baud_ctrl_reg[`SBQ_B_RUN];
      if (!baud_ctrl_reg[`SBQ_B_RUN]) begin
        ovf_cnt_reg <= 4'h0;                         // stopped
      end else if (!run_dly_reg || tmr_ovf) begin
        // first run cycle loads before counting
        timer_reg <= {reload_hi_reg, reload_lo_reg};
        if (tmr_ovf)
          ovf_cnt_reg <= ovf_cnt_reg + 4'h1;
      end else begin
        timer_reg <= timer_reg + 16'h0001;
      end
    end
  end

  // fixed dividers and port tick outputs per mode
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      div4_reg       <= 2'h0;
      div6_reg       <= 3'h0;
      div16_reg      <= 4'h0;
      PORT0_TICK_OUT <= 1'b0;
      PORT1_TICK_OUT <= 1'b0;
    end else begin
      div6_reg  <= div6_reg == `SBQ_DIV_SIX ? 3'h0 : div6_reg + 3'h1;
      div16_reg <= div16_reg + 4'h1;
      if (tick_raw)
        div4_reg <= div4_reg + 2'h1;
      unique case (mode_reg)
        SBQ_MODE_SHIFT: begin
          PORT0_TICK_OUT <= div6_reg == `SBQ_DIV_SIX;
          PORT1_TICK_OUT <= div6_reg == `SBQ_DIV_SIX;
        end
        SBQ_MODE_9FIX: begin
          PORT0_TICK_OUT <= div16_reg == `SBQ_DIV_SIXTEEN;
          PORT1_TICK_OUT <= div16_reg == `SBQ_DIV_SIXTEEN;
        end
        SBQ_MODE_8BIT, SBQ_MODE_9BAUD: begin
          PORT0_TICK_OUT <= tick_raw;
          PORT1_TICK_OUT <= tick_raw &&
            (!baud_ctrl_reg[`SBQ_B_DIV4] || div4_reg == `SBQ_DIV_FOUR);
        end
      endcase
    end
  end

  // receive control: cpu rights, queue events, end of frame
  always_ff @(posedge CLK_IN) begin
    logic [7:0] w;
    logic [7:0] n;
    logic       hit;
    w   = `SBQ_ZERO8;
    n   = rx_ctrl_reg;
    hit = 1'b0;
    if (PERIPH_RST_IN) begin
      rx_ctrl_reg  <= `SBQ_ZERO8;
      rx_ptr_reg   <= `SBQ_ZERO8;
      rx_cnt_reg   <= `SBQ_ZERO8;
      rx_match_reg <= `SBQ_ZERO8;
      rx_pend_reg  <= 1'b0;
      rx_data_reg  <= `SBQ_ZERO8;
    end else begin
      if (wr && PADDR_IN == `SBQ_A_QCTRL && PSTRB_IN[0]) begin
        w = PWDATA_IN[7:0];
        n = (rx_ctrl_reg & ~`SBQ_RX_WMASK) | (w & `SBQ_RX_WMASK);
        if (!w[`SBQ_B_OVR])
          n[`SBQ_B_OVR] = 1'b0;                      // clear only
        n[`SBQ_B_ACTIVE] = rx_ctrl_reg[`SBQ_B_ACTIVE] |
                           w[`SBQ_B_ACTIVE];         // set only
      end
      if (wr && PADDR_IN == `SBQ_A_RX_PTR)
        rx_ptr_reg <= lane(rx_ptr_reg, PADDR_IN);
      if (wr && PADDR_IN == `SBQ_A_RX_CNT)
        rx_cnt_reg <= lane(rx_cnt_reg, PADDR_IN);
      if (wr && PADDR_IN == `SBQ_A_RX_MATCH)
        rx_match_reg <= lane(rx_match_reg, PADDR_IN);
      // byte with queue on but frame idle: overrun wins over clear
      if (RX_BYTE_VALID_IN && rx_ctrl_reg[`SBQ_B_EN] &&
          !rx_ctrl_reg[`SBQ_B_ACTIVE])
        n[`SBQ_B_OVR] = 1'b1;
      if (rx_take && !rx_ctrl_reg[`SBQ_B_PAUSE]) begin
        rx_pend_reg <= 1'b1;
        rx_data_reg <= RX_BYTE_IN;
      end
      if (rx_pend_reg && ram_own_reg == SBQ_RAM_RX) begin
        rx_pend_reg <= 1'b0;
        rx_ptr_reg  <= (rx_last && rx_ctrl_reg[`SBQ_B_REWIND]) ?
                       `SBQ_ZERO8 : rx_ptr_reg + 8'h01;
        rx_cnt_reg  <= rx_cnt_reg - 8'h01;
        if (rx_last && !rx_ctrl_reg[`SBQ_B_WRAP])
          n[`SBQ_B_ACTIVE] = 1'b0;
      end
      if (!n[`SBQ_B_EN])
        n[`SBQ_B_ACTIVE] = 1'b0;
      rx_ctrl_reg <= n;
    end
  end

  // transmit control, pointer, count and irq flags
  always_ff @(posedge CLK_IN) begin
    logic [7:0] w;
    logic [7:0] n;
    w = `SBQ_ZERO8;
    n = tx_ctrl_reg;
    if (PERIPH_RST_IN) begin
      tx_ctrl_reg  <= `SBQ_ZERO8;
      tx_ptr_reg   <= `SBQ_ZERO8;
      tx_cnt_reg   <= `SBQ_ZERO8;
      tx_busy_reg  <= 1'b0;
      tx_fetch_reg <= 1'b0;
      TX_LOAD_OUT  <= 1'b0;
      TX_BYTE_OUT  <= `SBQ_ZERO8;
    end else begin
      TX_LOAD_OUT <= 1'b0;
      if (wr && PADDR_IN == `SBQ_A_QCTRL && PSTRB_IN[1]) begin
        w = PWDATA_IN[15:8];
        n = (tx_ctrl_reg & ~`SBQ_Q_TX_WMASK) | (w & `SBQ_Q_TX_WMASK);
        if (!w[`SBQ_B_TIF]) n[`SBQ_B_TIF] = 1'b0;
        if (!w[`SBQ_B_RIF]) n[`SBQ_B_RIF] = 1'b0;
        n[`SBQ_B_TSTF] = tx_ctrl_reg[`SBQ_B_TSTF] | w[`SBQ_B_TSTF];
      end
      if (wr && PADDR_IN == `SBQ_A_TX_PTR)
        tx_ptr_reg <= lane(tx_ptr_reg, PADDR_IN);
      if (wr && PADDR_IN == `SBQ_A_TX_CNT)
        tx_cnt_reg <= lane(tx_cnt_reg, PADDR_IN);
      // receive flag events, set beats a same-cycle clear
      if (rx_pend_reg && ram_own_reg == SBQ_RAM_RX &&
          (rx_ctrl_reg[`SBQ_B_PERBYTE] || rx_last ||
           (rx_ctrl_reg[`SBQ_B_MATCH] && rx_data_reg == rx_match_reg)))
        n[`SBQ_B_RIF] = 1'b1;
      if (tx_ctrl_reg[`SBQ_B_TEN] && tx_ctrl_reg[`SBQ_B_TSTF] &&
          !tx_ctrl_reg[`SBQ_B_THLT] && !tx_busy_reg && !tx_fetch_reg)
        tx_fetch_reg <= 1'b1;
      if (tx_fetch_reg && ram_own_reg == SBQ_RAM_TX) begin
        tx_fetch_reg <= 1'b0;
        tx_busy_reg  <= 1'b1;
        TX_LOAD_OUT  <= 1'b1;
        TX_BYTE_OUT  <= ram_mem[tx_ptr_reg];
      end
      if (tx_busy_reg && TX_DONE_IN) begin
        tx_busy_reg <= 1'b0;
        tx_ptr_reg  <= tx_ptr_reg + 8'h01;
        tx_cnt_reg  <= tx_cnt_reg - 8'h01;
        if (tx_last) n[`SBQ_B_TSTF] = 1'b0;
        if (tx_last || tx_ctrl_reg[`SBQ_B_TIE]) n[`SBQ_B_TIF] = 1'b1;
      end
      if (!n[`SBQ_B_TEN]) n[`SBQ_B_TSTF] = 1'b0;
      tx_ctrl_reg <= n;
    end
  end

  // ram owner: queue first, one cycle per access
  always_ff @(posedge CLK_IN) begin
    if (PERIPH_RST_IN) begin
      ram_own_reg <= SBQ_RAM_IDLE;
    end else if (ram_busy) begin
      ram_own_reg <= SBQ_RAM_IDLE;
    end else if (rx_pend_reg) begin
      ram_own_reg <= SBQ_RAM_RX;
    end else if (tx_fetch_reg) begin
      ram_own_reg <= SBQ_RAM_TX;
    end
  end

  // queue ram: receive stores win the port, cpu waits
  always_ff @(posedge CLK_IN) begin
    if (ram_own_reg == SBQ_RAM_RX)
      ram_mem[rx_ptr_reg] <= rx_data_reg;
    // a tx fetch only reads, so a cpu store can share its cycle
    else if (wr && ram_hit && PSTRB_IN[0])
      ram_mem[PADDR_IN[9:2]] <= PWDATA_IN[7:0];
  end

  // read mux
  always_comb begin
    prdata_next = 32'h0000_0000;
    if (ram_hit)
      prdata_next[7:0] = ram_mem[PADDR_IN[9:2]];
    else
      unique case (PADDR_IN)
        `SBQ_A_BAUD_CTRL: prdata_next[7:0] = baud_ctrl_reg;
        `SBQ_A_RELOAD_LO: prdata_next[7:0] = reload_lo_reg;
        `SBQ_A_RELOAD_HI: prdata_next[7:0] = reload_hi_reg;
        `SBQ_A_QCTRL:     prdata_next[15:0] = {tx_ctrl_reg, rx_ctrl_reg};
        `SBQ_A_TX_PTR:    prdata_next[7:0] = tx_ptr_reg;
        `SBQ_A_TX_CNT:    prdata_next[7:0] = tx_cnt_reg;
        `SBQ_A_RX_PTR:    prdata_next[7:0] = rx_ptr_reg;
        `SBQ_A_RX_CNT:    prdata_next[7:0] = rx_cnt_reg;
        `SBQ_A_RX_MATCH:  prdata_next[7:0] = rx_match_reg;
        `SBQ_A_SER_MODE:  prdata_next[1:0] = mode_reg;
        default:          prdata_next = 32'h0000_0000;
      endcase
  end

  // apb answer: no wait state, up to 4 on a ram window access while queue wants or owns ram
  // a pending rx byte also holds the cpu off, else its store is lost
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      PREADY_OUT  <= 1'b0;
      PRDATA_OUT  <= 32'h0000_0000;
      PSLVERR_OUT <= 1'b0;
      stall_reg   <= 3'h0;
    end else if (PSEL_IN && !PREADY_OUT &&
                 !(ram_hit && (rx_pend_reg || tx_fetch_reg || ram_busy) &&
                   stall_reg != `SBQ_STALL_MAX)) begin
      PREADY_OUT  <= 1'b1;
      PRDATA_OUT  <= prdata_next;
      PSLVERR_OUT <= 1'b0;
      stall_reg   <= 3'h0;
    end else begin
      if (PSEL_IN && !PREADY_OUT)
        stall_reg <= stall_reg + 3'h1;
      PREADY_OUT <= 1'b0;
    end
  end

  // direct cpu path when the receive queue is off
  always_ff @(posedge CLK_IN) begin
    if (PERIPH_RST_IN) begin
      RX_CPU_VALID_OUT <= 1'b0;
      RX_CPU_BYTE_OUT  <= `SBQ_ZERO8;
      RX_IRQ_FLAG_OUT  <= 1'b0;
      TX_IRQ_FLAG_OUT  <= 1'b0;
    end else begin
      RX_CPU_VALID_OUT <= RX_BYTE_VALID_IN && !rx_ctrl_reg[`SBQ_B_EN];
      if (RX_BYTE_VALID_IN && !rx_ctrl_reg[`SBQ_B_EN])
        RX_CPU_BYTE_OUT <= RX_BYTE_IN;
      RX_IRQ_FLAG_OUT <= tx_ctrl_reg[`SBQ_B_RIF];
      TX_IRQ_FLAG_OUT <= tx_ctrl_reg[`SBQ_B_TIF];
    end
  end

  // checks
  // a queue store: byte waiting while the queue holds the ram port
  sequence rx_store_s;
    rx_pend_reg && ram_own_reg == SBQ_RAM_RX;
  endsequence
  stall_bound_a: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    stall_reg <= `SBQ_STALL_MAX) else $error("cpu stall too long");
  ovr_set_a: assert property (
    @(posedge CLK_IN) disable iff (PERIPH_RST_IN)
    RX_BYTE_VALID_IN && rx_ctrl_reg[`SBQ_B_EN] &&
    !rx_ctrl_reg[`SBQ_B_ACTIVE] |=> rx_ctrl_reg[`SBQ_B_OVR])
    else $error("overrun not flagged");
  active_drop_a: assert property (
    @(posedge CLK_IN) disable iff (PERIPH_RST_IN)
    !rx_ctrl_reg[`SBQ_B_EN] |-> !rx_ctrl_reg[`SBQ_B_ACTIVE])
    else $error("active without enable");
  rx_step_a: assert property (
    @(posedge CLK_IN) disable iff (PERIPH_RST_IN)
    rx_store_s ##0 !wr |=> rx_cnt_reg == $past(rx_cnt_reg) - 8'h01)
    else $error("rx count");
  reload_load_a: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    tmr_ovf && !wr |=> timer_reg == {reload_hi_reg, reload_lo_reg})
    else $error("no reload on overflow");
  run_stop_a: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    !baud_ctrl_reg[`SBQ_B_RUN] && !run_dly_reg |=> $stable(timer_reg))
    else $error("timer moved when stopped");
  p0_tick_a: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    mode_reg == SBQ_MODE_8BIT && $past(mode_reg) == SBQ_MODE_8BIT
    |-> PORT0_TICK_OUT == $past(tick_raw)) else $error("port0 tick");
  wrap_keep_a: assert property (
    @(posedge CLK_IN) disable iff (PERIPH_RST_IN)
    rx_store_s ##0 (rx_ctrl_reg[`SBQ_B_WRAP] && rx_ctrl_reg[`SBQ_B_EN])
    |=> rx_ctrl_reg[`SBQ_B_ACTIVE]) else $error("wrap lost frame");
endmodule

// File: rtl/sbq_defs.svh
// constants and bit positions for the serial baud timer and frame queue
`ifndef SBQ_DEFS_SVH
`define SBQ_DEFS_SVH
`define SBQ_A_BAUD_CTRL   12'h000
`define SBQ_A_RELOAD_LO   12'h004
`define SBQ_A_RELOAD_HI   12'h008
`define SBQ_A_QCTRL       12'h00C
`define SBQ_A_TX_PTR      12'h010
`define SBQ_A_TX_CNT      12'h014
`define SBQ_A_RX_PTR      12'h018
`define SBQ_A_RX_CNT      12'h01C
`define SBQ_A_RX_MATCH    12'h020
`define SBQ_A_SER_MODE    12'h024
`define SBQ_A_RAM_BASE    12'h400
`define SBQ_B_DIV4        0
`define SBQ_B_RUN         1
`define SBQ_B_EN          7
`define SBQ_B_MATCH       6
`define SBQ_B_PERBYTE     5
`define SBQ_B_WRAP        4
`define SBQ_B_OVR         3
`define SBQ_B_REWIND      2
`define SBQ_B_PAUSE       1
`define SBQ_B_ACTIVE      0
`define SBQ_B_TIF         7
`define SBQ_B_RIF         6
`define SBQ_B_TEN         3
`define SBQ_B_TIE         2
`define SBQ_B_THLT        1
`define SBQ_B_TSTF        0
`define SBQ_Q_TX_WMASK    8'h0E
`define SBQ_RX_WMASK      8'hF6
`define SBQ_ZERO8         8'h00
`define SBQ_ONE8          8'h01
`define SBQ_TOP16         16'hFFFF
`define SBQ_OVF_PER_TICK  4'hF
`define SBQ_DIV_SIX       3'h5
`define SBQ_DIV_SIXTEEN   4'hF
`define SBQ_DIV_FOUR      2'h3
`define SBQ_STALL_MAX     3'h4
`define SBQ_BAUD_WMASK    8'h03
`define SBQ_RAM_SEL       2'h1
`endif

// File: rtl/sbq_pkg.sv
// types for the serial baud timer and frame queue
package sbq_pkg;
  typedef enum logic [1:0] {
    SBQ_MODE_SHIFT = 2'h0,
    SBQ_MODE_8BIT  = 2'h1,
    SBQ_MODE_9FIX  = 2'h2,
    SBQ_MODE_9BAUD = 2'h3
  } sbq_mode_t;
  typedef enum logic [1:0] {
    SBQ_RAM_IDLE = 2'h0,
    SBQ_RAM_RX   = 2'h1,
    SBQ_RAM_TX   = 2'h2
  } sbq_ram_t;
endpackage

// File: bench/sbq_serial_partner.sv
// far-side serial port model: delivers received bytes, consumes tx loads
`timescale 1ns/100ps
module sbq_serial_partner (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       tx_load_in,
  input  wire logic [7:0] tx_byte_in,
  output logic            rx_valid_out,
  output logic      [7:0] rx_byte_out,
  output logic            tx_done_out
);
  logic [7:0] tx_seen[$];  // bytes the port was asked to send
  int         wait_cnt;    // cycles left on the line for one byte

  // idle line, nothing in flight
  initial begin
    rx_valid_out = 1'b0;
    rx_byte_out = 8'h5A;
    tx_done_out = 1'b0;
    wait_cnt = 0;
  end

  // one byte per pulse; data goes stale afterwards so nothing reads it late
  task automatic send_byte(input logic [7:0] b);
    @(posedge clk_in);
    rx_valid_out <= 1'b1;
    rx_byte_out <= b;
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_byte_out <= ~b;
    repeat (8) @(posedge clk_in);
  endtask

  // alternate prompt and slow finish, a real line is never instant
  always @(posedge clk_in) begin
    tx_done_out <= 1'b0;
    if (rst_in) begin
      wait_cnt <= 0;
    end else if (tx_load_in) begin
      tx_seen.push_back(tx_byte_in);
      wait_cnt <= (tx_seen.size() % 2) ? 2 : 9;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
      tx_done_out <= (wait_cnt == 1);
    end
  end
endmodule

// File: bench/test_serial_baud_and_frame_queue.sv
// self-checking bench for the baud timer and port zero frame queue
`timescale 1ns/100ps
`include "sbq_defs.svh"
module test_serial_baud_and_frame_queue;
  logic        CLK_IN = 1'b0;       // 125 MHz system clock
  logic        SYS_RST_IN = 1'b1;   // cpu reset
  logic        PERIPH_RST_IN = 1'b1;  // peripheral reset
  logic        PSEL_IN = 1'b0;
  logic        PENABLE_IN = 1'b0;
  logic        PWRITE_IN = 1'b0;
  logic [11:0] PADDR_IN = 12'h000;
  logic [31:0] PWDATA_IN = 32'h0;
  logic [3:0]  PSTRB_IN = 4'h0;
  logic [31:0] PRDATA_OUT;
  logic        PREADY_OUT, PSLVERR_OUT, TX_LOAD_OUT, RX_CPU_VALID_OUT;
  logic        PORT0_TICK_OUT, PORT1_TICK_OUT, RX_IRQ_FLAG_OUT;
  logic        TX_IRQ_FLAG_OUT, RX_BYTE_VALID_IN, TX_DONE_IN;
  logic [7:0]  RX_BYTE_IN, TX_BYTE_OUT, RX_CPU_BYTE_OUT, cpu_byte;
  logic [7:0]  b[3];                // bytes of the receive frame
  logic [31:0] rd;                  // last read data
  logic [15:0] reload;              // baud reload value
  int          miscompares = 0;
  int          checks = 0;
  int          seed = 32'h41433F03;
  int          cpu_cnt = 0;         // bytes seen on the direct path
  int          mem[256];            // expected queue RAM
  int          p, n, ptr;

  always #4 CLK_IN = ~CLK_IN;

  sbq_top dut (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .PERIPH_RST_IN(PERIPH_RST_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PSTRB_IN(PSTRB_IN), .PRDATA_OUT(PRDATA_OUT),
    .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .RX_BYTE_VALID_IN(RX_BYTE_VALID_IN), .RX_BYTE_IN(RX_BYTE_IN),
    .TX_DONE_IN(TX_DONE_IN), .TX_LOAD_OUT(TX_LOAD_OUT),
    .TX_BYTE_OUT(TX_BYTE_OUT), .RX_CPU_VALID_OUT(RX_CPU_VALID_OUT),
    .RX_CPU_BYTE_OUT(RX_CPU_BYTE_OUT), .PORT0_TICK_OUT(PORT0_TICK_OUT),
    .PORT1_TICK_OUT(PORT1_TICK_OUT), .RX_IRQ_FLAG_OUT(RX_IRQ_FLAG_OUT),
    .TX_IRQ_FLAG_OUT(TX_IRQ_FLAG_OUT));

  sbq_serial_partner pm (.clk_in(CLK_IN), .rst_in(PERIPH_RST_IN),
    .tx_load_in(TX_LOAD_OUT), .tx_byte_in(TX_BYTE_OUT),
    .rx_valid_out(RX_BYTE_VALID_IN), .rx_byte_out(RX_BYTE_IN),
    .tx_done_out(TX_DONE_IN));

  // count bytes handed straight to the cpu
  always @(posedge CLK_IN) begin
    if (RX_CPU_VALID_OUT === 1'b1) begin
      cpu_cnt++;
      cpu_byte = RX_CPU_BYTE_OUT;
    end
  end

  task automatic close_out();
    if (miscompares == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      miscompares++;
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int i = 0;
    @(posedge CLK_IN);
    PSEL_IN <= 1'b1;
    PWRITE_IN <= w;
    PADDR_IN <= a;
    PWDATA_IN <= d;
    PSTRB_IN <= w ? s : 4'h0;
    @(posedge CLK_IN);
    PENABLE_IN <= 1'b1;
    do begin
      @(posedge CLK_IN);
      i++;
    end while (PREADY_OUT !== 1'b1 && i < 20);
    rd = PRDATA_OUT;
    check("slave error", PSLVERR_OUT, 0);
    PSEL_IN <= 1'b0;
    PENABLE_IN <= 1'b0;
    if (PREADY_OUT !== 1'b1) begin
      miscompares++;
      close_out();
    end
  endtask

  // read a register and compare its low half word
  task automatic rc(input string nm, input logic [11:0] a, input int e);
    apb(1'b0, a, 32'h0, 4'h0);
    check(nm, {16'h0, rd[15:0]}, e);
  endtask

  // word address of one queue RAM byte
  function automatic logic [11:0] ram_a(input int o);
    return {2'b01, o[7:0], 2'b00};
  endfunction

  // cycles between two ticks of one port, bounded
  task automatic period(input logic one, output int c);
    int k = 0;
    while ((one ? PORT1_TICK_OUT : PORT0_TICK_OUT) !== 1'b1 && k < 3000) begin
      @(posedge CLK_IN);
      k++;
    end
    c = 0;
    do begin
      @(posedge CLK_IN);
      c++;
    end while ((one ? PORT1_TICK_OUT : PORT0_TICK_OUT) !== 1'b1 && c < 3000);
    if (k >= 3000 || c >= 3000) begin
      miscompares++;
      close_out();
    end
  endtask

  initial begin
    repeat (16) @(posedge CLK_IN);
    SYS_RST_IN <= 1'b0;
    PERIPH_RST_IN <= 1'b0;
    rc("baud ctrl reset", `SBQ_A_BAUD_CTRL, 0);
    rc("queue ctrl reset", `SBQ_A_QCTRL, 0);
    rc("unmapped read", 12'h300, 0);
    // every port mode; baud modes use a random reload near the top
    for (int m = 0; m < 4; m++) begin
      reload = {12'hFFF, 4'($random(seed))};
      apb(1'b1, `SBQ_A_BAUD_CTRL, 32'h0, 4'hF);
      apb(1'b1, `SBQ_A_RELOAD_LO, {24'h0, reload[7:0]}, 4'hF);
      apb(1'b1, `SBQ_A_RELOAD_HI, {24'h0, reload[15:8]}, 4'hF);
      apb(1'b1, `SBQ_A_SER_MODE, m, 4'hF);
      apb(1'b1, `SBQ_A_BAUD_CTRL, {30'h0, 1'b1, m[1]}, 4'hF);
      p = 16 * (65536 - reload);
      repeat (2) period(1'b0, n);
      check("port0 period", n, m[0] ? p : (m[1] ? 16 : 6));
      if (m[0]) begin
        repeat (2) period(1'b1, n);
        check("port1 period", n, p << (2 * m[1]));
      end
    end
    // stopped timer makes no ticks
    apb(1'b1, `SBQ_A_BAUD_CTRL, 32'h0, 4'hF);
    repeat (4) @(posedge CLK_IN);
    p = 0;
    repeat (1500) begin
      @(posedge CLK_IN);
      p += PORT0_TICK_OUT;
    end
    check("stopped ticks", p, 0);
    // frame across the top of RAM, match on the middle byte
    ptr = 8'hFE;
    b[0] = $random(seed);
    b[1] = b[0] ^ 8'h5C;
    b[2] = $random(seed);
    apb(1'b1, `SBQ_A_RX_PTR, ptr, 4'hF);
    apb(1'b1, `SBQ_A_RX_CNT, 3, 4'hF);
    apb(1'b1, `SBQ_A_RX_MATCH, b[1], 4'hF);
    apb(1'b1, `SBQ_A_QCTRL, 32'h80, 4'h1);
    apb(1'b1, `SBQ_A_QCTRL, 32'hC1, 4'h1);
    for (int i = 0; i < 3; i++) begin
      pm.send_byte(b[i]);
      mem[(ptr + i) % 256] = b[i];
      check("rx flag", RX_IRQ_FLAG_OUT, i != 0);
      if (i == 1) apb(1'b1, `SBQ_A_QCTRL, 32'h0, 4'h2);
    end
    rc("rx ptr", `SBQ_A_RX_PTR, (ptr + 3) % 256);
    rc("rx cnt", `SBQ_A_RX_CNT, 0);
    rc("frame end", `SBQ_A_QCTRL, 16'h40C0);
    for (int i = 0; i < 3; i++) begin
      rc("rx ram", ram_a(ptr + i), mem[(ptr + i) % 256]);
    end
    // byte with frame inactive raises overrun; cpu may only clear it
    pm.send_byte(8'h33);
    rc("overrun set", `SBQ_A_QCTRL, 16'h40C8);
    apb(1'b1, `SBQ_A_QCTRL, 32'hC8, 4'h1);
    rc("overrun kept", `SBQ_A_QCTRL, 16'h40C8);
    apb(1'b1, `SBQ_A_QCTRL, 32'hC0, 4'h1);
    rc("overrun clear", `SBQ_A_QCTRL, 16'h40C0);
    apb(1'b1, `SBQ_A_QCTRL, 32'hC8, 4'h1);
    rc("overrun no set", `SBQ_A_QCTRL, 16'h40C0);
    // circular buffer: wrap keeps frame active, rewind returns to zero
    apb(1'b1, `SBQ_A_QCTRL, 32'h0, 4'h2);
    apb(1'b1, `SBQ_A_RX_PTR, 7, 4'hF);
    apb(1'b1, `SBQ_A_RX_CNT, 1, 4'hF);
    apb(1'b1, `SBQ_A_QCTRL, 32'h95, 4'h1);
    pm.send_byte(b[0]);
    check("wrap flag", RX_IRQ_FLAG_OUT, 1);
    rc("rewound ptr", `SBQ_A_RX_PTR, 0);
    rc("wrap active", `SBQ_A_QCTRL, 16'h4095);
    pm.send_byte(b[1]);
    rc("wrap no ovr", `SBQ_A_QCTRL, 16'h4095);
    rc("wrap ram 7", ram_a(7), b[0]);
    rc("wrap ram 0", ram_a(0), b[1]);
    // per-byte flag after a word write clears it, then pause drops a byte
    apb(1'b1, `SBQ_A_QCTRL, 32'hB5, 4'h3);
    pm.send_byte(b[2]);
    check("per-byte flag", RX_IRQ_FLAG_OUT, 1);
    apb(1'b1, `SBQ_A_QCTRL, 32'hB7, 4'h1);
    pm.send_byte(b[0]);
    rc("paused ptr", `SBQ_A_RX_PTR, 2);
    rc("paused ram", ram_a(1), b[2]);
    // queue off: bytes go straight to the cpu
    apb(1'b1, `SBQ_A_QCTRL, 32'h0, 4'h1);
    p = cpu_cnt;
    pm.send_byte(b[2]);
    check("direct count", cpu_cnt, p + 1);
    check("direct byte", cpu_byte, b[2]);
    // transmit two bytes from a random start
    ptr = $random(seed) & 255;
    for (int i = 0; i < 2; i++) begin
      mem[(ptr + i) % 256] = $random(seed) & 255;
      apb(1'b1, ram_a(ptr + i), mem[(ptr + i) % 256], 4'hF);
    end
    apb(1'b1, `SBQ_A_TX_PTR, ptr, 4'hF);
    apb(1'b1, `SBQ_A_TX_CNT, 2, 4'hF);
    apb(1'b1, `SBQ_A_QCTRL, 32'h0900, 4'h2);
    for (int k = 0; k < 300 && pm.tx_seen.size() < 2; k++) @(posedge CLK_IN);
    if (pm.tx_seen.size() < 2) begin
      miscompares++;
      close_out();
    end
    repeat (20) @(posedge CLK_IN);
    check("tx count", pm.tx_seen.size(), 2);
    for (int i = 0; i < 2; i++) begin
      check("tx byte", pm.tx_seen[i], mem[(ptr + i) % 256]);
    end
    rc("tx ptr", `SBQ_A_TX_PTR, (ptr + 2) % 256);
    rc("tx cnt", `SBQ_A_TX_CNT, 0);
    check("tx flag", TX_IRQ_FLAG_OUT, 1);
    close_out();
  end
endmodule
